// file: include/sov_pkg.sv
/*
  Shared constants and carrier types for the safety override controller.
  Assumes a single 50 MHz module clock and synchronous contact inputs.
*/
package sov_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_NS    = 20;
  localparam int unsigned DEBOUNCE_TIME_NS = 1000;
  localparam int unsigned DEBOUNCE_CYCLES  = (DEBOUNCE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================================
  // Sizes and reset values
  // ==========================================================================
  localparam int unsigned VOTE_WIDTH      = 3;
  localparam int unsigned NUM_OUT_MODULES = 4;
  localparam int unsigned NUM_OUTPUTS     = 8;
  localparam logic        OVR_RESET_VAL   = 1'b1;
  localparam logic        FAULT_RESET_VAL = 1'b0;

  // ==========================================================================
  // Register map for the plain register port
  // ==========================================================================
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_LOCAL  = 4'h2;

  localparam int unsigned CTRL_POWER_UP_PHASE_BIT = 0;
  localparam int unsigned CTRL_APP_GLB_BIT = 1;

  localparam int unsigned STAT_GLB_BIT    = 0;
  localparam int unsigned STAT_FAULT_BIT  = 1;
  localparam int unsigned STAT_TUNE_BIT   = 2;
  localparam int unsigned STAT_SAFEK_BIT  = 3;
  localparam int unsigned STAT_LMVOTE_BIT = 4;

  localparam logic [15:0] CTRL_RESET_VAL  = 16'h0001;
  localparam logic [15:0] LOCAL_RESET_VAL = 16'h0000;

  // ==========================================================================
  // Carrier types
  // ==========================================================================
  typedef struct packed {
    logic [VOTE_WIDTH-1:0] set_n;
    logic                  clear;
  } sov_contacts_t;

  typedef struct packed {
    logic override_active;
    logic tuning_active;
    logic downstream_safe;
    logic fault;
  } sov_monitor_t;

endpackage : sov_pkg

// file: hw/sov_ctrl.sv
/*
  Safety override controller: global and per-module override latches,
  2-out-of-3 contact voting, fault latch, tuning gate and monitor report.
  Assumes contact inputs are synchronous to i_mclk and that a power cycle
  is the only thing that asserts i_sys_rst.
*/
`timescale 1ns/1ps

module sov_ctrl
  import sov_pkg::*;
#(
  parameter int unsigned N_MOD    = NUM_OUT_MODULES,
  parameter int unsigned N_OUT    = NUM_OUTPUTS,
  parameter int unsigned DB_COUNT = DEBOUNCE_CYCLES
) (
  input  wire logic                  i_mclk,
  input  wire logic                  i_sys_rst,
  // Register port
  input  wire logic [3:0]            i_reg_addr,
  input  wire logic [15:0]           i_reg_wdata,
  input  wire logic                  i_reg_wr,
  input  wire logic                  i_reg_rd,
  output logic      [15:0]           o_reg_rdata,
  // Logic module contacts
  input  wire sov_contacts_t         i_lm_contacts,
  // Output module contacts
  input  wire sov_contacts_t [N_MOD-1:0] i_om_contacts,
  input  wire logic [N_MOD-1:0]      i_om_present,
  // Keys
  input  wire logic                  i_tuning_key,
  input  wire logic                  i_downstream_safe_key,
  // Power switch state feedback
  input  wire logic                  i_override_state_fb,
  // Tuning port
  input  wire logic [7:0]            i_tune_data,
  input  wire logic                  i_tune_valid,
  output logic                       o_tune_power,
  output logic      [7:0]            o_tune_data,
  output logic                       o_tune_valid,
  // Safety outputs
  input  wire logic [N_OUT-1:0]      i_normal_out [N_MOD],
  output logic      [N_OUT-1:0]      o_safe_out   [N_MOD],
  output logic      [N_MOD-1:0]      o_power_switch_closed,
  output logic                       o_global_override,
  // Remote monitor station report
  output sov_monitor_t               o_monitor
);

  // ==========================================================================
  // Elaboration checks
  // ==========================================================================
  // Local mask and readback are sixteen bits wide
  if (N_MOD < 1 || N_MOD > 16) begin : g_chk_mod
    $error("N_MOD out of range");
  end
  if (N_OUT < 1) begin : g_chk_out
    $error("N_OUT must be at least one");
  end
  if (DB_COUNT < 1) begin : g_chk_db
    $error("DB_COUNT must be at least one");
  end
  // The vote function serves exactly three set contacts
  if (VOTE_WIDTH != 3) begin : g_chk_vote
    $error("VOTE_WIDTH must be three");
  end

  localparam int unsigned NIN = (N_MOD + 1) * (VOTE_WIDTH + 1) + 2;
  localparam int unsigned CW  = $clog2(DB_COUNT + 1);

  function automatic logic vote2of3(input logic [2:0] v);
    vote2of3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction : vote2of3

  // Set keys rest closed; a zero reset would fake a set vote and a fault
  function automatic logic [NIN-1:0] idle_inputs();
    logic [NIN-1:0] v;
    v = '0;
    for (int g = 0; g <= N_MOD; g++) begin
      v[g*(VOTE_WIDTH+1)+1 +: VOTE_WIDTH] = '1;
    end
    return v;
  endfunction : idle_inputs

  localparam logic [NIN-1:0] IDLE_IN = idle_inputs();

  // ==========================================================================
  // Input synchronise and debounce
  // ==========================================================================
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] sync1_q;
  logic [NIN-1:0] sync2_q;
  logic [NIN-1:0] db_q;

  always_comb begin
    raw_in = '0;
    raw_in[VOTE_WIDTH:0] = {i_lm_contacts.set_n, i_lm_contacts.clear};
    for (int m = 0; m < N_MOD; m++) begin
      raw_in[(m+1)*(VOTE_WIDTH+1) +: VOTE_WIDTH+1] = {i_om_contacts[m].set_n, i_om_contacts[m].clear};
    end
    raw_in[NIN-2] = i_tuning_key;
    raw_in[NIN-1] = i_downstream_safe_key;
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sync1_q <= IDLE_IN;
      sync2_q <= IDLE_IN;
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end

  // Contacts that never settle keep their old value, so chatter cannot flip the latch
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_db
      logic [CW-1:0] cnt_q;
      logic          bit_q;
      always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          cnt_q <= '0;
          bit_q <= IDLE_IN[gi];
        end else if (sync2_q[gi] == bit_q) begin
          cnt_q <= '0;
        end else if (cnt_q == CW'(DB_COUNT - 1)) begin
          cnt_q <= '0;
          bit_q <= sync2_q[gi];
        end else begin
          cnt_q <= cnt_q + CW'(1);
        end
      end
      assign db_q[gi] = bit_q;
    end
  endgenerate

  // ==========================================================================
  // Contact decoding
  // ==========================================================================
  logic             lm_set_vote;
  logic             lm_keys_closed;
  logic             lm_clear;
  logic [N_MOD-1:0] om_set_vote;
  logic [N_MOD-1:0] om_keys_closed;
  logic [N_MOD-1:0] om_clear;
  logic             tune_key;
  logic             safe_key;

  always_comb begin
    // Inputs are high while the keyswitch is closed; an open key requests set
    lm_set_vote    = vote2of3(~db_q[VOTE_WIDTH:1]);
    lm_keys_closed = &db_q[VOTE_WIDTH:1];
    lm_clear       = db_q[0];
    for (int m = 0; m < N_MOD; m++) begin
      om_set_vote[m]    = vote2of3(~db_q[(m+1)*(VOTE_WIDTH+1)+1 +: VOTE_WIDTH]);
      om_keys_closed[m] = &db_q[(m+1)*(VOTE_WIDTH+1)+1 +: VOTE_WIDTH];
      om_clear[m]       = db_q[(m+1)*(VOTE_WIDTH+1)];
    end
    tune_key = db_q[NIN-2];
    safe_key = db_q[NIN-1];
  end

  // ==========================================================================
  // Register port
  // ==========================================================================
  logic [15:0] ctrl_q;
  logic [15:0] local_req_q;

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_q      <= CTRL_RESET_VAL;
      local_req_q <= LOCAL_RESET_VAL;
    end else if (i_reg_wr) begin
      if (i_reg_addr == REG_CTRL) begin
        ctrl_q <= i_reg_wdata;
      end else if (i_reg_addr == REG_LOCAL) begin
        local_req_q <= i_reg_wdata;
      end
    end
  end

  logic power_up_phase_set;
  logic app_global_set;

  assign power_up_phase_set    = ctrl_q[CTRL_POWER_UP_PHASE_BIT];
  assign app_global_set = ctrl_q[CTRL_APP_GLB_BIT];

  // ==========================================================================
  // Global override latch
  // ==========================================================================
  logic global_set_cond;
  logic clear_edge;
  logic lm_clear_prev_q;
  logic global_q;

  // Every output module sees the same majority; the logic module alone suffices
  assign global_set_cond = power_up_phase_set | app_global_set | lm_set_vote;

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      lm_clear_prev_q <= 1'b0;
    end else begin
      lm_clear_prev_q <= lm_clear;
    end
  end

  // One momentary closure counts once; holding the clear contact does nothing more
  assign clear_edge = lm_clear & ~lm_clear_prev_q;

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      global_q <= OVR_RESET_VAL;
    end else if (global_set_cond) begin
      global_q <= 1'b1;
    end else if (clear_edge && lm_keys_closed) begin
      global_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Local override latches
  // ==========================================================================
  logic [N_MOD-1:0] local_q;

  generate
    for (gi = 0; gi < N_MOD; gi++) begin : g_local
      logic set_cond;
      logic latch_q;
      logic clr_prev_q;
      assign set_cond = local_req_q[gi] | om_set_vote[gi];
      always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          latch_q    <= OVR_RESET_VAL;
          clr_prev_q <= 1'b0;
        end else begin
          clr_prev_q <= om_clear[gi];
          if (set_cond) begin
            latch_q <= 1'b1;
          end else if (om_clear[gi] && !clr_prev_q && om_keys_closed[gi]
                       && !global_set_cond && !global_q) begin
            latch_q <= 1'b0;
          end
        end
      end
      assign local_q[gi] = latch_q;
    end
  endgenerate

  // ==========================================================================
  // Fault latch
  // ==========================================================================
  logic fault_q;

  // Only the chassis reset clears this; override clears never touch it
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      fault_q <= FAULT_RESET_VAL;
    end else if (lm_set_vote && !i_override_state_fb) begin
      fault_q <= 1'b1;
    end
  end

  // ==========================================================================
  // Safety outputs and power switches
  // ==========================================================================
  logic [N_MOD-1:0] mod_safe;

  assign mod_safe = local_q | {N_MOD{global_q | fault_q}} | ~i_om_present;

  generate
    for (gi = 0; gi < N_MOD; gi++) begin : g_out
      logic pwr_q;
      always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          o_safe_out[gi] <= '0;
          pwr_q          <= 1'b0;
        end else begin
          // De-energise is the safe value
          o_safe_out[gi] <= mod_safe[gi] ? '0 : i_normal_out[gi];
          pwr_q          <= ~mod_safe[gi];
        end
      end
      assign o_power_switch_closed[gi] = pwr_q;
    end
  endgenerate

  // ==========================================================================
  // Tuning port gate
  // ==========================================================================
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_tune_power <= 1'b0;
      o_tune_data  <= '0;
      o_tune_valid <= 1'b0;
    end else begin
      o_tune_power <= tune_key;
      o_tune_valid <= tune_key & i_tune_valid;
      if (tune_key && i_tune_valid) begin
        o_tune_data <= i_tune_data;
      end
    end
  end

  // ==========================================================================
  // Monitor report and status read
  // ==========================================================================
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_monitor         <= '0;
      o_global_override <= OVR_RESET_VAL;
    end else begin
      o_monitor.override_active <= global_q | (|local_q);
      o_monitor.tuning_active   <= tune_key;
      o_monitor.downstream_safe <= safe_key;
      o_monitor.fault           <= fault_q;
      o_global_override         <= global_q;
    end
  end

  logic [15:0] status_w;

  always_comb begin
    status_w                  = '0;
    status_w[STAT_GLB_BIT]    = global_q;
    status_w[STAT_FAULT_BIT]  = fault_q;
    status_w[STAT_TUNE_BIT]   = tune_key;
    status_w[STAT_SAFEK_BIT]  = safe_key;
    status_w[STAT_LMVOTE_BIT] = lm_set_vote;
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_reg_rdata <= '0;
    end else if (i_reg_rd) begin
      if (i_reg_addr == REG_CTRL) begin
        o_reg_rdata <= ctrl_q;
      end else if (i_reg_addr == REG_STATUS) begin
        o_reg_rdata <= status_w;
      end else if (i_reg_addr == REG_LOCAL) begin
        o_reg_rdata <= 16'(local_q);
      end else begin
        o_reg_rdata <= '0;
      end
    end else begin
      o_reg_rdata <= '0;
    end
  end

endmodule : sov_ctrl

// file: dv/sov_ctrl_monitor.sv
/*
  Port checker for the safety override controller.
  Assumes the bench debounce count of 2, so inputs settle within eight cycles.
*/
`timescale 1ns/1ps

module sov_ctrl_monitor
  import sov_pkg::*;
#(
  parameter int unsigned N_MOD = NUM_OUT_MODULES,
  parameter int unsigned N_OUT = NUM_OUTPUTS
) (
  input wire logic                 i_mclk,
  input wire logic                 i_sys_rst,
  input wire sov_contacts_t        i_lm_contacts,
  input wire logic [N_MOD-1:0]     i_om_present,
  input wire logic                 i_tuning_key,
  input wire logic                 i_downstream_safe_key,
  input wire logic                 o_tune_power,
  input wire logic                 o_tune_valid,
  input wire logic [N_OUT-1:0]     o_safe_out [N_MOD],
  input wire logic [N_MOD-1:0]     o_power_switch_closed,
  input wire logic                 o_global_override,
  input wire sov_monitor_t         o_monitor
);
  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  logic lm_vote;
  // Two of three keys open
  assign lm_vote = (~i_lm_contacts.set_n[0] & ~i_lm_contacts.set_n[1]) |
                   (~i_lm_contacts.set_n[0] & ~i_lm_contacts.set_n[2]) |
                   (~i_lm_contacts.set_n[1] & ~i_lm_contacts.set_n[2]);

  chk_glb_outs_safe: assert property (
    o_global_override && $past(o_global_override) |-> o_safe_out[0] == '0 && o_safe_out[N_MOD-1] == '0)
    else $error("outputs not safe under global override");
  chk_glb_pwr_open: assert property (
    o_global_override && $past(o_global_override) |-> o_power_switch_closed == '0)
    else $error("power switch closed under global override");
  chk_set_vote: assert property (
    lm_vote [*8] |-> o_global_override)
    else $error("majority of open keys did not set override");
  chk_glb_clear: assert property (
    $fell(o_global_override) |-> $past(i_lm_contacts.clear, 2) && $past(i_lm_contacts.set_n, 2) == 3'b111)
    else $error("override cleared without clear contact and closed keys");
  chk_fault_hold: assert property (
    o_monitor.fault |=> o_monitor.fault)
    else $error("fault dropped without power cycle");
  chk_fault_safe: assert property (
    o_monitor.fault && $past(o_monitor.fault) |-> o_safe_out[0] == '0)
    else $error("outputs not safe while latched_fault_state");
  chk_removed_safe: assert property (
    !i_om_present[0] [*3] |-> o_safe_out[0] == '0)
    else $error("removed module outputs not safe");
  chk_tune_gate: assert property (
    o_tune_valid |-> o_tune_power && o_monitor.tuning_active)
    else $error("tuning beat without tuning key");
  chk_tune_off: assert property (
    !i_tuning_key [*8] |-> !o_tune_power)
    else $error("tuning port powered with key out");
  chk_dsafe_seen: assert property (
    i_downstream_safe_key [*8] |-> o_monitor.downstream_safe)
    else $error("downstream safe key not reported");

  cov_fault: cover property (o_monitor.fault);
  cov_clear: cover property ($fell(o_global_override));
  cov_tune: cover property (o_tune_valid);
endmodule : sov_ctrl_monitor

bind sov_ctrl sov_ctrl_monitor #(.N_MOD(N_MOD), .N_OUT(N_OUT)) u_mon (
  .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_lm_contacts(i_lm_contacts), .i_om_present(i_om_present),
  .i_tuning_key(i_tuning_key), .i_downstream_safe_key(i_downstream_safe_key), .o_tune_power(o_tune_power),
  .o_tune_valid(o_tune_valid), .o_safe_out(o_safe_out), .o_power_switch_closed(o_power_switch_closed),
  .o_global_override(o_global_override), .o_monitor(o_monitor));

// file: dv/sov_panel.sv
/*
  Operator panel model: set keys, clear contacts and power switch feedback.
  Assumes the bench changes its commands just after rising clock edges.
*/
`timescale 1ns/1ps

module sov_panel
  import sov_pkg::*;
#(
  parameter int unsigned N_MOD = 2
) (
  input  wire logic                 i_glb,
  input  wire logic [2:0]           i_lm_open,
  input  wire logic [N_MOD-1:0]     i_om_open,
  input  wire logic                 i_clr_lm,
  input  wire logic                 i_clr_om,
  input  wire logic                 i_fb_bad,
  output sov_contacts_t             o_lm,
  output sov_contacts_t [N_MOD-1:0] o_om,
  output logic                      o_fb
);
  logic vote;
  // Open key drops its line; clear is a plain closure
  assign o_lm = {~i_lm_open, i_clr_lm};
  always_comb begin
    for (int m = 0; m < N_MOD; m++) begin
      o_om[m] = {(i_om_open[m] ? 3'b100 : 3'b111), i_clr_om};
    end
  end
  assign vote = (i_lm_open[0] & i_lm_open[1]) | (i_lm_open[0] & i_lm_open[2]) | (i_lm_open[1] & i_lm_open[2]);
  // Key path opens the switch directly, so feedback leads the latch
  assign o_fb = ~i_fb_bad & (vote | i_glb);
endmodule : sov_panel

// file: dv/tb_top.sv
/*
  Self-checking bench for the safety override controller.
  Assumes a debounce count of 2 and two output modules of four outputs.
*/
`timescale 1ns/1ps

module tb_top;
  import sov_pkg::*;
  localparam int unsigned NM = 2;
  localparam int unsigned NO = 4;
  logic                   i_mclk, i_sys_rst, reg_wr, reg_rd, tkey, dkey, fb, tvalid;
  logic                   tpow, tvo, glb, rd_seen, fb_bad, clr_lm, clr_om;
  logic [3:0]             reg_addr;
  logic [15:0]            reg_wdata, rdata, r;
  logic [7:0]             tdata, tdo, tune_last;
  logic [2:0]             lm_open;
  logic [NM-1:0]          om_open, present, psw;
  logic [NO-1:0]          nout [NM];
  logic [NO-1:0]          sout [NM];
  sov_contacts_t          lm_c;
  sov_contacts_t [NM-1:0] om_c;
  sov_monitor_t           mon;
  logic [15:0]            exp_q [$];
  int                     err_count, checks, cyc, tune_cnt;

  sov_ctrl #(.N_MOD(NM), .N_OUT(NO), .DB_COUNT(2)) i_dut (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr),
    .i_reg_rd(reg_rd), .o_reg_rdata(rdata), .i_lm_contacts(lm_c), .i_om_contacts(om_c), .i_om_present(present),
    .i_tuning_key(tkey), .i_downstream_safe_key(dkey), .i_override_state_fb(fb), .i_tune_data(tdata),
    .i_tune_valid(tvalid), .o_tune_power(tpow), .o_tune_data(tdo), .o_tune_valid(tvo), .i_normal_out(nout),
    .o_safe_out(sout), .o_power_switch_closed(psw), .o_global_override(glb), .o_monitor(mon));
  sov_panel #(.N_MOD(NM)) i_panel (.i_glb(glb), .i_lm_open(lm_open), .i_om_open(om_open), .i_clr_lm(clr_lm),
    .i_clr_om(clr_om), .i_fb_bad(fb_bad), .o_lm(lm_c), .o_om(om_c), .o_fb(fb));

  // ==========================================================================
  // Clock, watchers and shared tasks
  // ==========================================================================
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic stop_test;
    if (err_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  always @(posedge i_mclk) begin
    cyc++;
    rd_seen <= reg_rd;
    if (tvo === 1'b1) begin
      tune_cnt++;
      tune_last <= tdo;
    end
    // Hang guard, well above the roughly five hundred cycles needed
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end
  always @(negedge i_mclk) if (rd_seen === 1'b1 && exp_q.size() > 0) chk("reg_rdata", rdata, exp_q.pop_front());
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_mclk);
  endtask : wait_cyc
  // Long enough for two sync flops, debounce and output stage
  task automatic settle;
    wait_cyc(14);
    #2;
  endtask : settle
  task automatic reg_op(input logic wr, input logic [3:0] a, input logic [15:0] d);
    if (!wr) exp_q.push_back(d);
    @(posedge i_mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= wr;
    reg_rd <= !wr;
    @(posedge i_mclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask : reg_op
  task automatic pulse_clr(input logic lm, input logic om);
    @(posedge i_mclk);
    clr_lm <= lm;
    clr_om <= om;
    wait_cyc(10);
    clr_lm <= 1'b0;
    clr_om <= 1'b0;
    settle();
  endtask : pulse_clr
  task automatic chk_outs(input logic [NM-1:0] safe);
    for (int m = 0; m < NM; m++) chk("safe_out", 16'(sout[m]), safe[m] ? 16'h0000 : 16'(nout[m]));
  endtask : chk_outs
  task automatic beat;
    @(posedge i_mclk);
    tdata <= r[15:8];
    tvalid <= 1'b1;
    @(posedge i_mclk);
    tvalid <= 1'b0;
    settle();
  endtask : beat

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    {reg_wr, reg_rd, tkey, dkey, tvalid, fb_bad, clr_lm, clr_om} = '0;
    {reg_addr, reg_wdata, tdata, lm_open, om_open} = '0;
    present = '1;
    r = 16'hE80E;
    nout[0] = r[3:0] | 4'h1;
    nout[1] = r[7:4] | 4'h1;
    i_sys_rst = 1'b1;
    wait_cyc(5);
    i_sys_rst <= 1'b0;
    settle();
    reg_op(1'b0, REG_CTRL, CTRL_RESET_VAL);
    reg_op(1'b0, REG_STATUS, 16'h0001);
    reg_op(1'b0, 4'hF, 16'h0000);
    chk("override_active", 16'(mon.override_active), 16'h0001);
    pulse_clr(1'b1, 1'b0);
    chk("glb_power_up_phase", 16'(glb), 16'h0001);
    reg_op(1'b1, REG_CTRL, 16'h0000);
    pulse_clr(1'b1, 1'b0);
    chk("glb_cleared", 16'(glb), 16'h0000);
    pulse_clr(1'b0, 1'b1);
    reg_op(1'b0, REG_LOCAL, 16'h0000);
    r = lfsr(r);
    @(posedge i_mclk) nout <= '{r[3:0] | 4'h1, r[7:4] | 4'h1};
    settle();
    chk_outs(2'b00);
    chk("pwr_on", 16'(psw), 16'h0003);
    @(posedge i_mclk) lm_open <= 3'b100;
    settle();
    chk("one_key", 16'(glb), 16'h0000);
    @(posedge i_mclk) lm_open <= 3'b011;
    pulse_clr(1'b1, 1'b0);
    chk("set_wins", 16'(glb), 16'h0001);
    chk("pwr_off", 16'(psw), 16'h0000);
    chk_outs(2'b11);
    reg_op(1'b0, REG_STATUS, 16'h0011);
    @(posedge i_mclk) lm_open <= 3'b000;
    pulse_clr(1'b1, 1'b0);
    chk("vote_cleared", 16'(glb), 16'h0000);
    reg_op(1'b1, REG_CTRL, 16'h0002);
    settle();
    chk_outs(2'b11);
    chk("app_pwr", 16'(psw), 16'h0000);
    pulse_clr(1'b1, 1'b0);
    chk("app_holds", 16'(glb), 16'h0001);
    reg_op(1'b1, REG_CTRL, 16'h0000);
    pulse_clr(1'b1, 1'b0);
    reg_op(1'b1, REG_LOCAL, 16'h0001);
    settle();
    chk_outs(2'b01);
    chk("local_pwr", 16'(psw), 16'h0002);
    reg_op(1'b0, REG_LOCAL, 16'h0001);
    reg_op(1'b1, REG_LOCAL, 16'h0000);
    pulse_clr(1'b0, 1'b1);
    @(posedge i_mclk) om_open <= 2'b10;
    settle();
    chk_outs(2'b10);
    @(posedge i_mclk) om_open <= 2'b00;
    pulse_clr(1'b0, 1'b1);
    chk_outs(2'b00);
    @(posedge i_mclk) present <= 2'b01;
    settle();
    chk_outs(2'b10);
    @(posedge i_mclk) present <= 2'b11;
    r = lfsr(r);
    beat();
    chk("tune_blocked", 16'(tune_cnt), 16'h0000);
    @(posedge i_mclk) tkey <= 1'b1;
    @(posedge i_mclk) dkey <= 1'b1;
    settle();
    chk("tune_power", 16'(tpow), 16'h0001);
    chk("tune_report", 16'(mon.tuning_active), 16'h0001);
    chk("dsafe", 16'(mon.downstream_safe), 16'h0001);
    beat();
    chk("tune_beats", 16'(tune_cnt), 16'h0001);
    chk("tune_data", 16'(tune_last), 16'(r[15:8]));
    reg_op(1'b0, REG_STATUS, 16'h000C);
    @(posedge i_mclk) fb_bad <= 1'b1;
    @(posedge i_mclk) lm_open <= 3'b110;
    settle();
    chk("fault_set", 16'(mon.fault), 16'h0001);
    @(posedge i_mclk) lm_open <= 3'b000;
    pulse_clr(1'b1, 1'b1);
    chk("fault_kept", 16'(mon.fault), 16'h0001);
    chk_outs(2'b11);
    @(posedge i_mclk) i_sys_rst <= 1'b1;
    wait_cyc(5);
    i_sys_rst <= 1'b0;
    settle();
    chk("fault_powercycle", 16'(mon.fault), 16'h0000);
    reg_op(1'b0, REG_STATUS, 16'h000D);
    settle();
    stop_test();
  end
endmodule : tb_top
